/* File: pkg/cms_pkg.sv */
package cms_pkg;
  // ----------------------------------------
  // register offsets and widths
  // ----------------------------------------
  localparam int unsigned CMS_ADDR_W = 16;
  localparam int unsigned CMS_DATA_W = 32;
  localparam logic [15:0] CMS_OFS_CONTROL = 16'h00ec;
  localparam logic [15:0] CMS_OFS_SINGLE = 16'h11f8;
  localparam logic [15:0] CMS_OFS_MULTI = 16'h11fc;

  // ----------------------------------------
  // control field layout
  // ----------------------------------------
  localparam int unsigned CMS_EN_LSB = 0;
  localparam int unsigned CMS_EN_W = 2;
  localparam int unsigned CMS_MODE_BIT = 2;
  localparam int unsigned CMS_SEL_LSB = 12;
  localparam int unsigned CMS_SEL_W = 5;
  localparam logic [1:0] CMS_EN_RESET = 2'h0;
  localparam logic CMS_MODE_RESET = 1'b0;
  localparam logic [4:0] CMS_SEL_RESET = 5'h00;

  // ----------------------------------------
  // status field layout
  // ----------------------------------------
  localparam int unsigned CMS_STATE_W = 3;
  localparam int unsigned CMS_SFLAG_LSB = 3;
  localparam int unsigned CMS_MAX_CLUSTERS = 29;
  localparam int unsigned CMS_CNT_W = 16;

  // ----------------------------------------
  // error report fields
  // ----------------------------------------
  localparam int unsigned CMS_FRAME_W = 24;
  localparam int unsigned CMS_BLOCK_W = 8;
  localparam int unsigned CMS_BIT_W = 7;

  typedef struct packed {
    logic [1:0] enable;
    logic mode;
    logic [4:0] cluster_sel;
  } cms_ctrl_t;

  typedef struct packed {
    logic [CMS_FRAME_W-1:0] frame;
    logic [CMS_SEL_W-1:0] cluster;
    logic [CMS_BLOCK_W-1:0] block;
    logic [CMS_BIT_W-1:0] bit_ofs;
  } cms_err_rep_t;
endpackage

/* File: verilog/cms_flag_vec.sv */
`timescale 1ns/1ps
module cms_flag_vec
  import cms_pkg::*;
#(
  parameter int unsigned W = 29
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic [W-1:0] set,
  output logic [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } cms_fv_state_t;

  cms_fv_state_t s_q;
  cms_fv_state_t s_d;

  // sticky flags; reload of the image or reset wipes them, nothing else does
  always_comb
  begin
    s_d = s_q;
    if (clr)
    begin
      s_d.flags = '0;
    end
    else
    begin
      s_d.flags = s_q.flags | set;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign flags = s_q.flags;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sticky_hold_a: assert property (@(posedge clk) disable iff (rst)
    !clr |=> ((flags & $past(flags)) == $past(flags)))
    else $error("flag dropped without a clearing event");
  flag_set_a: assert property (@(posedge clk) disable iff (rst)
    (!clr && (set != '0)) |=> ((flags & $past(set)) == $past(set)))
    else $error("reported cluster error not flagged");
endmodule // cms_flag_vec

/* File: verilog/cms_scrub_regs.sv */
`timescale 1ns/1ps
module cms_scrub_regs
  import cms_pkg::*;
#(
  parameter int unsigned NUM_CLUSTERS = CMS_MAX_CLUSTERS
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [CMS_ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [CMS_DATA_W-1:0] REG_WDATA,
  output logic [CMS_DATA_W-1:0] REG_RDATA,
  output logic REG_RACK,
  input wire logic IMAGE_LOAD,
  input wire logic [CMS_STATE_W-1:0] ENGINE_STATE,
  input wire logic [NUM_CLUSTERS-1:0] SINGLE_HIT,
  input wire logic [NUM_CLUSTERS-1:0] MULTI_HIT,
  input wire logic [CMS_FRAME_W-1:0] HIT_FRAME,
  input wire logic [CMS_BLOCK_W-1:0] HIT_BLOCK,
  input wire logic [CMS_BIT_W-1:0] HIT_BIT,
  output logic [1:0] SCRUB_ENABLE,
  output logic SCRUB_MODE,
  output logic [CMS_SEL_W-1:0] CLUSTER_SEL,
  output cms_err_rep_t ERR_REPORT,
  output logic ERR_VALID,
  output logic ERR_DUAL,
  output logic ERR_OFFS_VALID,
  output logic REPAIR_OK,
  output logic [CMS_CNT_W-1:0] SINGLE_COUNT,
  output logic [CMS_CNT_W-1:0] MULTI_COUNT
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    cms_ctrl_t ctrl;
    cms_err_rep_t rep;
    logic rep_valid;
    logic rep_dual;
    logic offs_valid;
    logic repair_ok;
    logic [CMS_CNT_W-1:0] single_cnt;
    logic [CMS_CNT_W-1:0] multi_cnt;
    logic [CMS_DATA_W-1:0] rdata;
    logic rack;
  } cms_state_t;

  cms_state_t s_q;
  cms_state_t s_d;
  logic [NUM_CLUSTERS-1:0] single_flags;
  logic [NUM_CLUSTERS-1:0] multi_flags;
  logic sel_single;
  logic sel_multi;

  // number of clusters hit in one frame, each one its own error
  function automatic logic [CMS_CNT_W-1:0] hit_count(input logic [NUM_CLUSTERS-1:0] v);
    logic [CMS_CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < NUM_CLUSTERS; i++)
    begin
      n = n + CMS_CNT_W'(v[i]);
    end
    return n;
  endfunction

  // flag vector widened to a register word, unused bits zero
  function automatic logic [CMS_DATA_W-1:0] place_flags(input logic [NUM_CLUSTERS-1:0] v, input int unsigned lsb);
    logic [CMS_DATA_W-1:0] w;
    w = '0;
    for (int i = 0; i < NUM_CLUSTERS; i++)
    begin
      w[lsb+i] = v[i];
    end
    return w;
  endfunction

  // ----------------------------------------
  // sticky flag banks
  // ----------------------------------------
  // bit 0 of each hit vector is the southernmost cluster
  cms_flag_vec #(.W(NUM_CLUSTERS)) u_single_flags (
    .clk(CLK),
    .rst(RST),
    .clr(IMAGE_LOAD),
    .set(SINGLE_HIT),
    .flags(single_flags)
  );

  cms_flag_vec #(.W(NUM_CLUSTERS)) u_multi_flags (
    .clk(CLK),
    .rst(RST),
    .clr(IMAGE_LOAD),
    .set(MULTI_HIT),
    .flags(multi_flags)
  );

  // hits in the cluster software has chosen to watch
  assign sel_single = (32'(s_q.ctrl.cluster_sel) < NUM_CLUSTERS) ? SINGLE_HIT[s_q.ctrl.cluster_sel] : 1'b0;
  assign sel_multi = (32'(s_q.ctrl.cluster_sel) < NUM_CLUSTERS) ? MULTI_HIT[s_q.ctrl.cluster_sel] : 1'b0;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rack = REG_RD;
    // only the control word is writable
    if (REG_WR && REG_ADDR == CMS_OFS_CONTROL)
    begin
      s_d.ctrl.enable = REG_WDATA[CMS_EN_LSB +: CMS_EN_W];
      s_d.ctrl.mode = REG_WDATA[CMS_MODE_BIT];
      s_d.ctrl.cluster_sel = REG_WDATA[CMS_SEL_LSB +: CMS_SEL_W];
    end
    // writes to status offsets fall through untouched
    // every hit cluster adds one to its counter
    s_d.single_cnt = s_q.single_cnt + hit_count(SINGLE_HIT);
    s_d.multi_cnt = s_q.multi_cnt + hit_count(MULTI_HIT);
    // dual error keeps frame and cluster, offsets invalid, no repair
    if (sel_multi)
    begin
      s_d.rep.frame = HIT_FRAME;
      s_d.rep.cluster = s_q.ctrl.cluster_sel;
      s_d.rep.block = '0;
      s_d.rep.bit_ofs = '0;
      s_d.rep_valid = 1'b1;
      s_d.rep_dual = 1'b1;
      s_d.offs_valid = 1'b0;
      s_d.repair_ok = 1'b0;
    end
    else if (sel_single)
    begin
      s_d.rep.frame = HIT_FRAME;
      s_d.rep.cluster = s_q.ctrl.cluster_sel;
      s_d.rep.block = HIT_BLOCK;
      s_d.rep.bit_ofs = HIT_BIT;
      s_d.rep_valid = 1'b1;
      s_d.rep_dual = 1'b0;
      s_d.offs_valid = 1'b1;
      s_d.repair_ok = s_q.ctrl.mode;
    end
    // a fresh image wipes holds and counters, control survives
    if (IMAGE_LOAD)
    begin
      s_d.rep = '0;
      s_d.rep_valid = 1'b0;
      s_d.rep_dual = 1'b0;
      s_d.offs_valid = 1'b0;
      s_d.repair_ok = 1'b0;
      s_d.single_cnt = '0;
      s_d.multi_cnt = '0;
    end
    // read mux; unmapped offsets return zero
    s_d.rdata = '0;
    if (REG_RD)
    begin
      case (REG_ADDR)
        CMS_OFS_CONTROL:
        begin
          s_d.rdata[CMS_EN_LSB +: CMS_EN_W] = s_q.ctrl.enable;
          s_d.rdata[CMS_MODE_BIT] = s_q.ctrl.mode;
          s_d.rdata[CMS_SEL_LSB +: CMS_SEL_W] = s_q.ctrl.cluster_sel;
        end
        // engine state below, per-cluster flags above
        CMS_OFS_SINGLE: s_d.rdata = place_flags(single_flags, CMS_SFLAG_LSB) | CMS_DATA_W'(ENGINE_STATE);
        CMS_OFS_MULTI: s_d.rdata = place_flags(multi_flags, 0);
        default: s_d.rdata = '0;
      endcase
    end
  end

  // reset values are constants; reset stands in for the config reset
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      s_q <= '0;
      s_q.ctrl.enable <= CMS_EN_RESET;
      s_q.ctrl.mode <= CMS_MODE_RESET;
      s_q.ctrl.cluster_sel <= CMS_SEL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs, all straight from state flops
  // ----------------------------------------
  assign REG_RDATA = s_q.rdata;
  assign REG_RACK = s_q.rack;
  assign SCRUB_ENABLE = s_q.ctrl.enable;
  assign SCRUB_MODE = s_q.ctrl.mode;
  assign CLUSTER_SEL = s_q.ctrl.cluster_sel;
  assign ERR_REPORT = s_q.rep;
  assign ERR_VALID = s_q.rep_valid;
  assign ERR_DUAL = s_q.rep_dual;
  assign ERR_OFFS_VALID = s_q.offs_valid;
  assign REPAIR_OK = s_q.repair_ok;
  assign SINGLE_COUNT = s_q.single_cnt;
  assign MULTI_COUNT = s_q.multi_cnt;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  ctrl_write_a: assert property (
    (REG_WR && REG_ADDR == CMS_OFS_CONTROL) |=> (CLUSTER_SEL == $past(REG_WDATA[16:12])
      && SCRUB_ENABLE == $past(REG_WDATA[1:0]) && SCRUB_MODE == $past(REG_WDATA[2])))
    else $error("control write not stored");
  state_read_a: assert property (
    (REG_RD && REG_ADDR == CMS_OFS_SINGLE) |=> (REG_RDATA[2:0] == $past(ENGINE_STATE) && REG_RACK))
    else $error("engine state not returned");
  single_flag_read_a: assert property (
    (REG_RD && REG_ADDR == CMS_OFS_SINGLE) |=> (REG_RDATA[CMS_SFLAG_LSB] == $past(single_flags[0])))
    else $error("southern single flag misplaced");
  multi_flag_read_a: assert property (
    (REG_RD && REG_ADDR == CMS_OFS_MULTI) |=> (REG_RDATA[0] == $past(multi_flags[0])))
    else $error("southern multi flag misplaced");
  upper_zero_a: assert property (
    (REG_RD && REG_ADDR == CMS_OFS_MULTI) |=> ((REG_RDATA >> NUM_CLUSTERS) == '0))
    else $error("absent cluster flag nonzero");
  reload_clear_a: assert property (
    IMAGE_LOAD |=> (SINGLE_COUNT == '0 && MULTI_COUNT == '0 && !ERR_VALID))
    else $error("reload did not clear holds");
  split_count_a: assert property (
    (!IMAGE_LOAD && $countones(SINGLE_HIT) == 2) |=> (SINGLE_COUNT == $past(SINGLE_COUNT) + 16'h0002))
    else $error("clusters not counted separately");
  dual_report_a: assert property (
    (!IMAGE_LOAD && sel_multi) |=> (ERR_DUAL && !ERR_OFFS_VALID && !REPAIR_OK
      && ERR_REPORT.frame == $past(HIT_FRAME)))
    else $error("dual error reported wrongly");
  status_ro_a: assert property (
    (REG_WR && REG_ADDR != CMS_OFS_CONTROL) |=> $stable(s_q.ctrl))
    else $error("status write changed control");

  cover_single_c: cover property (!IMAGE_LOAD && sel_single ##1 ERR_OFFS_VALID);
  cover_dual_c: cover property (!IMAGE_LOAD && sel_multi ##1 ERR_DUAL);
  cover_reload_c: cover property (ERR_VALID ##1 IMAGE_LOAD);
endmodule // cms_scrub_regs

/* File: sim/test_cms_scrub_regs.sv */
`timescale 1ns/1ps
module test_cms_scrub_regs
  import cms_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  // a short fabric, so that the zero-filled upper flag bits are seen
  localparam int unsigned NC = 17;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic load = 1'b0;
  logic [2:0] state = 3'h0;
  logic [NC-1:0] s_hit = '0;
  logic [NC-1:0] m_hit = '0;
  logic [23:0] frame = 24'h00_0000;
  logic [7:0] blk = 8'h00;
  logic [6:0] bofs = 7'h00;
  logic [31:0] rdata;
  logic rack, mode, vld, dual, ofs_ok, rep_ok;
  logic [1:0] en;
  logic [4:0] sel;
  logic [15:0] scnt, mcnt;
  cms_err_rep_t rep;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [31:0] rv;

  // 50 MHz clock
  always #10 clk = ~clk;

  cms_scrub_regs #(.NUM_CLUSTERS(NC)) dut (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RACK(rack), .IMAGE_LOAD(load),
    .ENGINE_STATE(state), .SINGLE_HIT(s_hit), .MULTI_HIT(m_hit), .HIT_FRAME(frame), .HIT_BLOCK(blk),
    .HIT_BIT(bofs), .SCRUB_ENABLE(en), .SCRUB_MODE(mode), .CLUSTER_SEL(sel), .ERR_REPORT(rep),
    .ERR_VALID(vld), .ERR_DUAL(dual), .ERR_OFFS_VALID(ofs_ok), .REPAIR_OK(rep_ok),
    .SINGLE_COUNT(scnt), .MULTI_COUNT(mcnt));

  // ----------------------------------------
  // compare and bus helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rep(input cms_err_rep_t got, input cms_err_rep_t exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobe one cycle, answer is sampled one cycle later
  task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({31'h0, rack}, 32'h0000_0001);
    d = rdata;
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic hit(input logic [NC-1:0] s, input logic [NC-1:0] m, input logic [23:0] f,
                     input logic [7:0] b, input logic [6:0] t);
    @(posedge clk);
    s_hit <= s;
    m_hit <= m;
    frame <= f;
    blk <= b;
    bofs <= t;
    @(posedge clk);
    s_hit <= '0;
    m_hit <= '0;
    #1;
  endtask

  task automatic image_load;
    @(posedge clk);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_control;
    reg_read(CMS_OFS_CONTROL, rv);
    chk(rv, 32'h0000_0000);
    reg_write(CMS_OFS_CONTROL, 32'hffff_ffff);
    reg_read(CMS_OFS_CONTROL, rv);
    chk(rv, 32'h0001_f007);
    chk({24'h0, en, mode, sel}, 32'h0000_00ff);
    reg_write(CMS_OFS_CONTROL, 32'h0000_9005);
    reg_read(CMS_OFS_CONTROL, rv);
    chk({24'h0, en, mode, sel}, 32'h0000_0069);
    $display("test control done");
  endtask

  task automatic t_state;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      state <= i[2:0];
      reg_read(CMS_OFS_SINGLE, rv);
      chk(rv, {29'h0, i[2:0]});
    end
    $display("test engine state done");
  endtask

  // southernmost and northernmost clusters hit in one frame
  task automatic t_flags;
    image_load();
    hit(17'h1_0001, 17'h0_0000, 24'h00_0040, 8'h02, 7'h11);
    chk({16'h0, scnt}, 32'h0000_0002);
    reg_read(CMS_OFS_SINGLE, rv);
    chk(rv, 32'h0008_000f);
    hit(17'h0_0000, 17'h0_0002, 24'h00_0041, 8'h00, 7'h00);
    reg_read(CMS_OFS_MULTI, rv);
    chk(rv, 32'h0000_0002);
    chk({16'h0, mcnt}, 32'h0000_0001);
    reg_write(CMS_OFS_SINGLE, 32'h0000_0000);
    reg_write(CMS_OFS_MULTI, 32'hffff_ffff);
    reg_read(CMS_OFS_SINGLE, rv);
    chk(rv, 32'h0008_000f);
    reg_read(CMS_OFS_MULTI, rv);
    chk(rv, 32'h0000_0002);
    reg_read(16'h0100, rv);
    chk(rv, 32'h0000_0000);
    hit('1, '1, 24'h00_0042, 8'h00, 7'h00);
    reg_read(CMS_OFS_SINGLE, rv);
    chk(rv, 32'h000f_ffff);
    reg_read(CMS_OFS_MULTI, rv);
    chk(rv, 32'h0001_ffff);
    chk({scnt, mcnt}, 32'h0013_0012);
    $display("test flags done");
  endtask

  // selected cluster 9, repair mode
  task automatic t_report;
    image_load();
    hit(17'h0_0200, 17'h0_0000, 24'h50_8011, 8'h01, 7'h06);
    chk({28'h0, vld, dual, ofs_ok, rep_ok}, 32'h0000_000b);
    chk_rep(rep, {24'h50_8011, 5'h09, 8'h01, 7'h06});
    hit(17'h0_0200, 17'h0_0200, 24'h12_3456, 8'h05, 7'h1a);
    chk({28'h0, vld, dual, ofs_ok, rep_ok}, 32'h0000_000c);
    chk_rep(rep, {24'h12_3456, 5'h09, 8'h00, 7'h00});
    // select beyond the fabric: hits are flagged but no report is taken
    reg_write(CMS_OFS_CONTROL, 32'h0001_f005);
    hit('1, '0, 24'h00_0033, 8'h04, 7'h01);
    chk_rep(rep, {24'h12_3456, 5'h09, 8'h00, 7'h00});
    // detect-only mode: single error reported but not repairable
    reg_write(CMS_OFS_CONTROL, 32'h0000_9001);
    hit(17'h0_0200, 17'h0_0000, 24'h00_0077, 8'h03, 7'h7f);
    chk({28'h0, vld, dual, ofs_ok, rep_ok}, 32'h0000_000a);
    chk_rep(rep, {24'h00_0077, 5'h09, 8'h03, 7'h7f});
    $display("test report done");
  endtask

  task automatic t_clear;
    image_load();
    chk({scnt, mcnt}, 32'h0000_0000);
    chk({28'h0, vld, dual, ofs_ok, rep_ok}, 32'h0000_0000);
    reg_read(CMS_OFS_SINGLE, rv);
    chk(rv, 32'h0000_0007);
    reg_read(CMS_OFS_CONTROL, rv);
    chk(rv, 32'h0000_9001);
    hit(17'h0_0008, 17'h0_0000, 24'h00_0001, 8'h00, 7'h00);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({scnt, mcnt}, 32'h0000_0000);
    reg_read(CMS_OFS_CONTROL, rv);
    chk(rv, 32'h0000_0000);
    $display("test clear done");
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // main sequence, reset held for 8 cycles
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_control();
    t_state();
    t_flags();
    t_report();
    t_clear();
    close_out();
  end

  // watchdog: whole run is about a hundred cycles
  initial
  begin
    #40_000;
    n_mismatch++;
    close_out();
  end
endmodule // test_cms_scrub_regs
